// File: core/pcms_params.svh
// Constants for the program counter, memory map and return stack block.
// Assumes inclusion by the package and the design file.
`ifndef PCMS_PARAMS_SVH
`define PCMS_PARAMS_SVH
`define PCMS_PC_W 21
`define PCMS_SP_W 5
`define PCMS_STACK_DEPTH 31
`define PCMS_RESET_VEC 21'h000000
`define PCMS_VEC_HIGH 21'h000008
`define PCMS_VEC_LOW 21'h000018
`define PCMS_BOOT_LIMIT 21'h0007ff
`define PCMS_FLASH_LIMIT 21'h00ffff
`define PCMS_MODE_INT 2'h3
`define PCMS_MODE_EXT 2'h2
`define PCMS_MODE_BOOT 2'h1
`define PCMS_MODE_EXTD 2'h0
`define PCMS_CFG_WAIT_BIT 7
`define PCMS_CFG_RESET 8'h83
`define PCMS_MBC_WAIT_HI 5
`define PCMS_MBC_WAIT_LO 4
`define PCMS_ADDR_W 4
`define PCMS_A_CFG 4'h0
`define PCMS_A_MBC 4'h1
`define PCMS_A_SP 4'h2
`define PCMS_A_STACK_TOP_LOW 4'h3
`define PCMS_A_STACK_TOP_HIGH 4'h4
`define PCMS_A_STACK_TOP_UPPER 4'h5
`define PCMS_A_PCLH 4'h6
`define PCMS_A_PCLU 4'h7
`define PCMS_A_STAT 4'h8
`define PCMS_SP_FULL_BIT 7
`define PCMS_SP_UNF_BIT 6
`endif

// File: core/pcms_pkg.sv
// Types for the program counter, memory map and return stack block.
// Assumes the params header sits beside it.
`include "pcms_params.svh"
package pcms_pkg;
  typedef enum logic [1:0] {
    PCMS_SRC_NONE,
    PCMS_SRC_INT,
    PCMS_SRC_EXT
  } pcms_src_t;
  typedef enum logic [2:0] {
    PCMS_OP_NONE,
    PCMS_OP_PUSH,
    PCMS_OP_POP
  } pcms_op_t;
endpackage

// File: core/pcms_core.sv
// Program counter, program memory map and 31-level return stack.
// Assumes fetch unit drives one op per cycle; memories answer outside.
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "pcms_params.svh"
module pcms_core
  import pcms_pkg::*;
#(
  parameter int FLASH_LIMIT = `PCMS_FLASH_LIMIT,
  parameter bit HAS_EXT_BUS = 1'b1
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_fault_reset_en,
  input wire logic i_fetch_adv,
  input wire logic [`PCMS_PC_W-1:0] i_fetch_next,
  input wire logic i_call,
  input wire logic [`PCMS_PC_W-1:0] i_call_target,
  input wire logic i_ret,
  input wire logic i_int_ack,
  input wire logic i_int_high,
  input wire logic i_tbl_req,
  input wire logic i_tbl_wr,
  input wire logic [`PCMS_PC_W-1:0] i_tbl_addr,
  input wire logic [`PCMS_ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic [`PCMS_PC_W-1:0] o_pc,
  output logic o_fetch_int,
  output logic o_fetch_ext,
  output logic o_fetch_zero,
  output logic o_tbl_int,
  output logic o_tbl_ext,
  output logic o_tbl_zero,
  output logic [1:0] o_wait_states,
  output logic o_stack_reset_req
);

  ////////////////////////////////////////////////////////////////////////
  // Registers and storage
  logic [`PCMS_PC_W-1:0] pc_r;
  logic [`PCMS_PC_W-1:0] pc_nxt;
  logic [`PCMS_SP_W-1:0] sp_r;
  logic full_r;
  logic unf_r;
  logic [7:0] cfg_r;
  logic [7:0] mbc_r;
  logic [7:0] pclh_r;
  logic [4:0] pclu_r;
  logic [`PCMS_PC_W-1:0] stack_mem [1:`PCMS_STACK_DEPTH];
  logic [`PCMS_PC_W-1:0] tos;
  logic [1:0] map_sel;
  pcms_op_t op;

  // Address to source decode, shared by fetch and table access
  function automatic pcms_src_t map_src(input logic [1:0] sel,
                                         input logic [`PCMS_PC_W-1:0] a);
    logic in_flash;
    in_flash = ({11'h000, a} <= FLASH_LIMIT);
    case (sel)
      `PCMS_MODE_EXT: map_src = PCMS_SRC_EXT;
      `PCMS_MODE_BOOT:
        map_src = (a <= `PCMS_BOOT_LIMIT) ? PCMS_SRC_INT
                                          : PCMS_SRC_EXT;
      `PCMS_MODE_EXTD:
        map_src = in_flash ? PCMS_SRC_INT : PCMS_SRC_EXT;
      default: map_src = in_flash ? PCMS_SRC_INT : PCMS_SRC_NONE;
    endcase
  endfunction

  assign map_sel = HAS_EXT_BUS ? cfg_r[1:0] : `PCMS_MODE_INT;
  assign tos = (sp_r == '0) ? '0 : stack_mem[sp_r];

  always_comb begin
    if (i_int_ack || i_call) begin
      op = PCMS_OP_PUSH;
    end else if (i_ret) begin
      op = PCMS_OP_POP;
    end else begin
      op = PCMS_OP_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Program counter
  always_comb begin
    pc_nxt = pc_r;
    if (i_int_ack) begin
      pc_nxt = i_int_high ? `PCMS_VEC_HIGH : `PCMS_VEC_LOW;
    end else if (i_call) begin
      pc_nxt = i_call_target;
    end else if (i_ret) begin
      pc_nxt = tos;
    end else if (i_fetch_adv) begin
      pc_nxt = i_fetch_next;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pc_r <= `PCMS_RESET_VEC;
    end else begin
      pc_r <= pc_nxt;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pc <= `PCMS_RESET_VEC;
      o_fetch_int <= 1'b0;
      o_fetch_ext <= 1'b0;
      o_fetch_zero <= 1'b0;
    end else begin
      o_pc <= pc_nxt;
      o_fetch_int <= map_src(map_sel, pc_nxt) == PCMS_SRC_INT;
      o_fetch_ext <= map_src(map_sel, pc_nxt) == PCMS_SRC_EXT;
      o_fetch_zero <= map_src(map_sel, pc_nxt) == PCMS_SRC_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Table access routing
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_tbl_int <= 1'b0;
      o_tbl_ext <= 1'b0;
      o_tbl_zero <= 1'b0;
    end else begin
      o_tbl_int <= i_tbl_req &&
                   map_src(map_sel, i_tbl_addr) == PCMS_SRC_INT;
      o_tbl_ext <= i_tbl_req &&
                   map_src(map_sel, i_tbl_addr) == PCMS_SRC_EXT;
      o_tbl_zero <= i_tbl_req && !i_tbl_wr &&
                    map_src(map_sel, i_tbl_addr) == PCMS_SRC_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Wait states
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wait_states <= 2'h0;
    end else if (cfg_r[`PCMS_CFG_WAIT_BIT]) begin
      o_wait_states <= 2'h0;
    end else begin
      o_wait_states <= mbc_r[`PCMS_MBC_WAIT_HI:`PCMS_MBC_WAIT_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Return stack pointer and flags
  logic sw_sp_wr;
  logic sw_tos_wr;
  assign sw_sp_wr = i_wr && i_addr == `PCMS_A_SP;
  assign sw_tos_wr = i_wr && (i_addr == `PCMS_A_STACK_TOP_LOW ||
                     i_addr == `PCMS_A_STACK_TOP_HIGH || i_addr == `PCMS_A_STACK_TOP_UPPER);

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sp_r <= '0;
    end else if (op == PCMS_OP_PUSH) begin
      if (sp_r != `PCMS_STACK_DEPTH) begin
        sp_r <= sp_r + 1'b1;
      end else if (i_fault_reset_en) begin
        sp_r <= '0;
      end
    end else if (op == PCMS_OP_POP) begin
      if (sp_r != '0) begin
        sp_r <= sp_r - 1'b1;
      end
    end else if (sw_sp_wr) begin
      sp_r <= i_wdata[`PCMS_SP_W-1:0];
    end
  end

  // Flags are set by hardware over a software clear in the same cycle
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      full_r <= 1'b0;
      unf_r <= 1'b0;
    end else begin
      if (op == PCMS_OP_PUSH &&
          sp_r >= `PCMS_STACK_DEPTH - 1) begin
        full_r <= 1'b1;
      end else if (sw_sp_wr && !i_wdata[`PCMS_SP_FULL_BIT]) begin
        full_r <= 1'b0;
      end
      if (op == PCMS_OP_POP && sp_r == '0) begin
        unf_r <= 1'b1;
      end else if (sw_sp_wr && !i_wdata[`PCMS_SP_UNF_BIT]) begin
        unf_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_stack_reset_req <= 1'b0;
    end else begin
      o_stack_reset_req <= i_fault_reset_en &&
        ((op == PCMS_OP_PUSH && sp_r >= `PCMS_STACK_DEPTH - 1) ||
         (op == PCMS_OP_POP && sp_r == '0));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Stack storage writes
  logic [`PCMS_SP_W-1:0] sp_inc;
  assign sp_inc = sp_r + 1'b1;

  always_ff @(posedge i_core_clk) begin
    if (op == PCMS_OP_PUSH && sp_r != `PCMS_STACK_DEPTH) begin
      stack_mem[sp_inc] <= pc_r;
    end else if (op == PCMS_OP_NONE && sw_tos_wr && sp_r != '0) begin
      case (i_addr)
        `PCMS_A_STACK_TOP_LOW: stack_mem[sp_r][7:0] <= i_wdata;
        `PCMS_A_STACK_TOP_HIGH: stack_mem[sp_r][15:8] <= i_wdata;
        default: stack_mem[sp_r][20:16] <= i_wdata[4:0];
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration and latch registers
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_r <= `PCMS_CFG_RESET;
      mbc_r <= 8'h00;
    end else if (i_wr && i_addr == `PCMS_A_CFG) begin
      cfg_r <= {i_wdata[7], 5'h00, i_wdata[1:0]};
    end else if (i_wr && i_addr == `PCMS_A_MBC) begin
      mbc_r <= i_wdata;
    end
  end

  // Only software writes the latches; calls and returns never do
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pclh_r <= 8'h00;
      pclu_r <= 5'h00;
    end else if (i_wr && i_addr == `PCMS_A_PCLH) begin
      pclh_r <= i_wdata;
    end else if (i_wr && i_addr == `PCMS_A_PCLU) begin
      pclu_r <= i_wdata[4:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read port
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `PCMS_A_CFG: o_rdata <= cfg_r;
        `PCMS_A_MBC: o_rdata <= mbc_r;
        `PCMS_A_SP: o_rdata <= {full_r, unf_r, 1'b0, sp_r};
        `PCMS_A_STACK_TOP_LOW: o_rdata <= tos[7:0];
        `PCMS_A_STACK_TOP_HIGH: o_rdata <= tos[15:8];
        `PCMS_A_STACK_TOP_UPPER: o_rdata <= {3'h0, tos[20:16]};
        `PCMS_A_PCLH: o_rdata <= pclh_r;
        `PCMS_A_PCLU: o_rdata <= {3'h0, pclu_r};
        `PCMS_A_STAT: o_rdata <= {6'h00, map_sel};
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  push_incr_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_call && !i_int_ack && sp_r < 5'h1e |=> sp_r == $past(sp_r) + 1'b1)
    else $error("push did not increment pointer");
  pop_decr_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_ret && !i_call && !i_int_ack && sp_r != 5'h00 |=>
    sp_r == $past(sp_r) - 1'b1)
    else $error("pop did not decrement pointer");
  full_hold_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_call && sp_r == 5'h1f && !i_fault_reset_en |=> sp_r == 5'h1f && full_r)
    else $error("full pointer moved");
  unf_set_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_ret && !i_call && !i_int_ack && sp_r == 5'h00 |=>
    unf_r && sp_r == 5'h00 && pc_r == 21'h0)
    else $error("underflow not handled");
  vector_hi_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_int_ack && i_int_high |=> pc_r == 21'h8 && o_pc == 21'h8)
    else $error("bad high vector");
  vector_lo_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_int_ack && !i_int_high |=> pc_r == 21'h18)
    else $error("bad low vector");
  ext_never_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    map_sel == 2'h3 |=> !o_fetch_ext && !o_tbl_ext)
    else $error("external access in internal map");
  wait_off_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    cfg_r[7] |=> o_wait_states == 2'h0)
    else $error("waits while disabled");
  push_store_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_call && !i_int_ack && sp_r < 5'h1f |=> tos == $past(pc_r))
    else $error("pushed value wrong");
  latch_keep_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (i_call || i_ret) && !i_wr |=> $stable(pclh_r) && $stable(pclu_r))
    else $error("latch changed by call");
  call_jump_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_call && !i_int_ack |=> o_pc == $past(i_call_target))
    else $error("call did not jump to target");
  pop_load_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    op == PCMS_OP_POP |=> pc_r == $past(tos))
    else $error("pop loaded wrong value");
  full_set_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    op == PCMS_OP_PUSH && sp_r == 5'h1e |=> full_r && sp_r == 5'h1f)
    else $error("full flag not set on last level");
  full_keep_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    full_r && !sw_sp_wr |=> full_r)
    else $error("full flag cleared by hardware");
  unf_keep_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    unf_r && !sw_sp_wr |=> unf_r)
    else $error("underflow flag cleared by hardware");
  ovf_reset_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_fault_reset_en && op == PCMS_OP_PUSH && sp_r == 5'h1f |=>
    sp_r == 5'h00 && full_r && o_stack_reset_req)
    else $error("overflow with reset option mishandled");
  tos_write_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    op == PCMS_OP_NONE && sw_tos_wr && i_addr == `PCMS_A_STACK_TOP_LOW &&
    sp_r != 5'h00 |=> tos[7:0] == $past(i_wdata))
    else $error("top of stack write lost");
  tbl_idle_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    !i_tbl_req |=> !o_tbl_int && !o_tbl_ext && !o_tbl_zero)
    else $error("table route without request");
  ext_only_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    map_sel == `PCMS_MODE_EXT |=> !o_fetch_int && !o_tbl_int)
    else $error("internal access in external map");
  boot_flash_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    map_sel == `PCMS_MODE_BOOT && pc_nxt <= `PCMS_BOOT_LIMIT |=>
    o_fetch_int)
    else $error("boot block not fetched from flash");
  rdata_idle_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    !i_rd |=> o_rdata == 8'h00)
    else $error("read data outside read cycle");

endmodule

// File: bench/pcms_mem_model.sv
// Program memory seen by the fetch unit: flash and external bus.
// Assumes the route flags of the core select which memory answers.
`timescale 1ns/1ps
`include "pcms_params.svh"
module pcms_mem_model
  import pcms_pkg::*;
(
  input wire logic [`PCMS_PC_W-1:0] i_pc,
  input wire logic i_int,
  input wire logic i_ext,
  input wire logic i_zero,
  output logic [15:0] o_word
);
  ////////////////////////////////////////////////////////////////////////
  // Distinct patterns so a wrong route shows in the word
  always_comb begin
    if (i_int && !i_zero) begin
      o_word = {4'ha, i_pc[11:0]};
    end else if (i_ext && !i_zero) begin
      o_word = {4'h5, i_pc[11:0]};
    end else begin
      o_word = 16'h0000;
    end
  end
endmodule

// File: bench/testbench.sv
// Self-checking bench for the program counter and return stack core.
// Assumes the default flash limit and an external bus being present.
`timescale 1ns/1ps
`include "pcms_params.svh"
module testbench;
  import pcms_pkg::*;
  typedef logic [`PCMS_PC_W-1:0] pcms_pc_t;
  logic i_core_clk, i_rst, i_fetch_adv, i_call, i_ret, i_int_ack;
  logic i_int_high, i_tbl_req, i_tbl_wr, i_wr, i_rd;
  pcms_pc_t i_fetch_next, i_call_target, i_tbl_addr, o_pc, a, ep;
  pcms_pc_t q[$];
  pcms_pc_t cn[4] = '{21'h0007ff, 21'h000800, 21'h00ffff, 21'h1fffff};
  logic [3:0] i_addr;
  logic [7:0] i_wdata, o_rdata, d;
  logic [1:0] o_wait_states;
  logic [2:0] r;
  logic o_fetch_int, o_fetch_ext, o_fetch_zero;
  logic o_tbl_int, o_tbl_ext, o_tbl_zero;
  logic fre, o_stack_reset_req;
  logic [15:0] word, ew;
  integer seed, fails, compares, m, j, k;

  pcms_core i_dut (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_fault_reset_en(fre), .i_fetch_adv(i_fetch_adv),
    .i_fetch_next(i_fetch_next), .i_call(i_call),
    .i_call_target(i_call_target), .i_ret(i_ret), .i_int_ack(i_int_ack),
    .i_int_high(i_int_high), .i_tbl_req(i_tbl_req), .i_tbl_wr(i_tbl_wr),
    .i_tbl_addr(i_tbl_addr), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_pc(o_pc),
    .o_fetch_int(o_fetch_int), .o_fetch_ext(o_fetch_ext),
    .o_fetch_zero(o_fetch_zero), .o_tbl_int(o_tbl_int),
    .o_tbl_ext(o_tbl_ext), .o_tbl_zero(o_tbl_zero),
    .o_wait_states(o_wait_states), .o_stack_reset_req(o_stack_reset_req));
  pcms_mem_model i_mem (.i_pc(o_pc), .i_int(o_fetch_int),
    .i_ext(o_fetch_ext), .i_zero(o_fetch_zero), .o_word(word));

  ////////////////////////////////////////////////////////////////////////
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  task chk(input logic [20:0] seen, input logic [20:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task wrap_up;
    $display("fails=%0d compares=%0d", fails, compares);
    if (fails == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task wr(input logic [3:0] ad, input logic [7:0] dt);
    @(posedge i_core_clk);
    i_addr <= ad;
    i_wdata <= dt;
    i_wr <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask

  task rd(input logic [3:0] ad, output logic [7:0] dt);
    @(posedge i_core_clk);
    i_addr <= ad;
    i_rd <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 dt = o_rdata;
  endtask

  // Kinds: 0 fetch, 1 call, 2 return, 3/4 interrupt, 5/6 table access
  task op(input integer kd, input pcms_pc_t t);
    @(posedge i_core_clk);
    i_fetch_next <= t;
    i_call_target <= t;
    i_tbl_addr <= t;
    i_fetch_adv <= (kd == 0);
    i_call <= (kd == 1);
    i_ret <= (kd == 2);
    i_int_ack <= (kd == 3 || kd == 4);
    i_int_high <= (kd == 3);
    i_tbl_req <= (kd >= 5);
    i_tbl_wr <= (kd == 6);
    @(posedge i_core_clk);
    {i_fetch_adv, i_call, i_ret, i_int_ack, i_tbl_req} <= 5'h00;
    #1;
  endtask

  // Route as {internal, external, zero}
  function automatic logic [2:0] er(input logic [1:0] md, input pcms_pc_t ad);
    logic fl;
    fl = (md == `PCMS_MODE_BOOT) ? (ad <= `PCMS_BOOT_LIMIT)
                                 : (ad <= `PCMS_FLASH_LIMIT);
    if (md == `PCMS_MODE_EXT) fl = 1'b0;
    if (fl) er = 3'h4;
    else if (md != `PCMS_MODE_INT) er = 3'h2;
    else er = 3'h1;
  endfunction

  initial begin
    #200000;
    fails++;
    wrap_up;
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'hfa415a2d;
    fails = 0;
    compares = 0;
    {i_fetch_adv, i_call, i_ret, i_int_ack, i_int_high} = 5'h00;
    {i_tbl_req, i_tbl_wr, i_wr, i_rd} = 4'h0;
    fre = 1'b0;
    i_fetch_next = '0;
    i_call_target = '0;
    i_tbl_addr = '0;
    i_addr = 4'h0;
    i_wdata = 8'h00;
    i_rst = 1'b1;
    repeat (4) @(posedge i_core_clk);
    i_rst <= 1'b0;
    #1 chk(o_pc, `PCMS_RESET_VEC);
    rd(`PCMS_A_CFG, d);
    chk(d, `PCMS_CFG_RESET);
    rd(`PCMS_A_SP, d);
    chk(d, 8'h00);
    for (m = 0; m < 4; m++) begin
      wr(`PCMS_A_CFG, {6'h20, 2'(m)});
      for (j = 0; j < 10; j++) begin
        a = (j < 4) ? cn[j] : pcms_pc_t'($random(seed));
        r = er(2'(m), a);
        op(0, a);
        chk(o_pc, a);
        chk({o_fetch_int, o_fetch_ext, o_fetch_zero}, r);
        ew = r[2] ? {4'ha, a[11:0]} : r[1] ? {4'h5, a[11:0]} : 16'h0000;
        chk(word, ew);
        op(5 + j % 2, a);
        chk({o_tbl_int, o_tbl_ext, o_tbl_zero}, (j % 2) ? r & 3'h6 : r);
      end
    end
    ep = a;
    wr(`PCMS_A_MBC, 8'h20);
    wr(`PCMS_A_CFG, 8'h03);
    @(posedge i_core_clk);
    #1 chk(o_wait_states, 2'h2);
    rd(`PCMS_A_STAT, d);
    chk(d, 8'h03);
    rd(`PCMS_A_MBC, d);
    chk(d, 8'h20);
    wr(`PCMS_A_CFG, 8'h83);
    @(posedge i_core_clk);
    #1 chk(o_wait_states, 2'h0);
    wr(`PCMS_A_PCLH, 8'h5a);
    wr(`PCMS_A_PCLU, 8'hff);
    for (j = 0; j < 32; j++) begin
      k = (j % 3 == 0) ? 3 : (j % 3 == 1) ? 4 : 1;
      a = pcms_pc_t'($random(seed));
      op(k, a);
      if (j < 31) q.push_back(ep);
      ep = (k == 3) ? `PCMS_VEC_HIGH : (k == 4) ? `PCMS_VEC_LOW : a;
      if (j < 31) chk(o_pc, ep);
      rd(`PCMS_A_SP, d);
      chk(d, (j >= 30) ? 8'h9f : 8'(j + 1));
      rd(`PCMS_A_STACK_TOP_LOW, d);
      chk(d, q[$][7:0]);
    end
    rd(`PCMS_A_STACK_TOP_HIGH, d);
    chk(d, q[$][15:8]);
    rd(`PCMS_A_STACK_TOP_UPPER, d);
    chk(d, {3'h0, q[$][20:16]});
    wr(`PCMS_A_STACK_TOP_LOW, 8'hc3);
    wr(`PCMS_A_STACK_TOP_UPPER, 8'h15);
    q[$][7:0] = 8'hc3;
    q[$][20:16] = 5'h15;
    for (j = 0; j < 32; j++) begin
      op(2, 0);
      ep = (j < 31) ? q.pop_back() : 0;
      chk(o_pc, ep);
    end
    rd(`PCMS_A_SP, d);
    chk(d, 8'hc0);
    wr(`PCMS_A_SP, 8'h00);
    rd(`PCMS_A_SP, d);
    chk(d, 8'h00);
    rd(`PCMS_A_PCLH, d);
    chk(d, 8'h5a);
    rd(`PCMS_A_PCLU, d);
    chk(d, 8'h1f);
    @(posedge i_core_clk);
    fre <= 1'b1;
    wr(`PCMS_A_SP, 8'h1e);
    op(1, pcms_pc_t'($random(seed)));
    chk(o_stack_reset_req, 1'b1);
    op(4, 0);
    chk(o_stack_reset_req, 1'b1);
    rd(`PCMS_A_SP, d);
    chk(d, 8'h80);
    op(2, 0);
    chk(o_stack_reset_req, 1'b1);
    chk(o_pc, 0);
    op(0, pcms_pc_t'($random(seed)));
    chk(o_stack_reset_req, 1'b0);
    fre <= 1'b0;
    wr(`PCMS_A_SP, 8'hc5);
    rd(`PCMS_A_SP, d);
    chk(d, 8'hc5);
    wr(`PCMS_A_CFG, 8'h01);
    @(posedge i_core_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    i_rst <= 1'b0;
    #1 chk(o_pc, `PCMS_RESET_VEC);
    rd(`PCMS_A_SP, d);
    chk(d, 8'h00);
    rd(`PCMS_A_CFG, d);
    chk(d, `PCMS_CFG_RESET);
    rd(4'hf, d);
    chk(d, 8'h00);
    wrap_up;
  end
endmodule
